// *** sbs_lin_peer.sv ***
// Behavioural LIN peer that sends a break and then one data byte
`timescale 1ns/1ns
module sbs_lin_peer #(
	parameter int BIT_NS = 80
) (
	output logic line,
	output logic busy,
	input wire logic go,
	input wire logic [7:0] val
);
	// Idle high like a pulled-up bus; one process owns both outputs
	initial begin
		line = 1'b1;
		busy = 1'b0;
		// Break of thirteen low bits, recovery gap, then one 8N1 byte LSB first
		forever begin
			@(posedge go);
			busy = 1'b1;
			#7 line = 1'b0; // Falling edge is the wake event
			#(13 * BIT_NS) line = 1'b1; // Rising edge ends the break
			#(2 * BIT_NS) line = 1'b0;
			for (int i = 0; i < 8; i++) begin
				#(BIT_NS) line = val[i]; // Byte after the break
			end
			#(BIT_NS) line = 1'b1;
			#(2 * BIT_NS) busy = 1'b0;
		end
	end
endmodule : sbs_lin_peer

// *** sbs_pkg.sv ***
// Shared constants, register layout and types for the break/sync serial port
package sbs_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] SBS_A_CTRL = 8'h00;
	localparam logic [7:0] SBS_A_STAT = 8'h04;
	localparam logic [7:0] SBS_A_TXD = 8'h08;
	localparam logic [7:0] SBS_A_RXD = 8'h0C;
	localparam logic [7:0] SBS_A_BAUD = 8'h10;
	// Status register bit positions
	localparam int SBS_S_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
	localparam int SBS_S_SHIFT_REGISTER_EMPTY_STATUS = 1;
	localparam int SBS_S_RCF = 2;
	localparam int SBS_S_RXIDLE = 3;
	// Reset values
	localparam logic [15:0] SBS_BAUD_RST = 16'h000F;
	localparam logic [8:0] SBS_CTRL_RST = 9'h000;
	// Frame lengths in bits, start and stop included where sent
	localparam logic [3:0] SBS_N_BRK = 4'hE;
	localparam logic [3:0] SBS_N_A8 = 4'hA;
	localparam logic [3:0] SBS_N_A9 = 4'hB;
	localparam logic [3:0] SBS_N_S8 = 4'h8;
	localparam logic [3:0] SBS_N_S9 = 4'h9;
	localparam logic [3:0] SBS_N_RXD = 4'h8;
	// Break frame: start, twelve zeros, stop
	localparam logic [13:0] SBS_BRK_FRAME = 14'h2000;
	// Holding-to-shift transfer time
	localparam int SBS_CLK_NS = 10;
	localparam int SBS_TCY_NS = 10;
	localparam int SBS_TCY_CYC = (SBS_TCY_NS + SBS_CLK_NS - 1) / SBS_CLK_NS;
	// Control register layout, bit 0 is transmit_enable
	typedef struct packed {
		logic wake_on_receive_enable;
		logic transmit_ninth_bit;
		logic nine_bit_transmit_select;
		logic clock_idle_polarity;
		logic serial_port_enable;
		logic clock_source_select;
		logic sync_mode;
		logic send_break_request;
		logic transmit_enable;
	} sbs_ctrl_t;
	// Transmit sequencer, Gray along idle-load-shift
	typedef enum logic [1:0] {
		SBS_TX_IDLE = 2'b00,
		SBS_TX_LOAD = 2'b01,
		SBS_TX_SHIFT = 2'b11
	} sbs_tx_t;
	// Receive sequencer
	typedef enum logic [1:0] {
		SBS_RX_IDLE = 2'b00,
		SBS_RX_START = 2'b01,
		SBS_RX_DATA = 2'b11,
		SBS_RX_STOP = 2'b10
	} sbs_rx_t;
endpackage : sbs_pkg

// *** sbs_top.sv ***
// Serial port with break/sync transmit, wake-on-receive and synchronous master transmit
//
// Behaviour
// - Setting wake enable idles the receiver; a wake event sets receive-complete flag.
// - After the wake event, next rising line edge clears wake enable.
// - Reading receive data clears the wake flag; that data is dummy.
// - Break is start bit, twelve zero bits, stop bit.
// - Break sent when send-break and transmit enable set at shift load.
// - Break ignores the written byte; only zeros are shifted before the stop bit.
// - Send-break clears itself after the break stop bit.
// - Holding register takes next byte during break; sent normally afterwards.
// - Shift-empty status tracks break transmission like ordinary characters.
// - Wake mode catches two transitions, flags, then receives next byte.
// - Synchronous master is half duplex; tx and rx exclude each other.
// - Sync mode plus port enable turn pins into clock and data.
// - Synchronous master generates and drives the shift clock.
// - Clock polarity bit sets the idle clock level.
// - Shift register reloads only after last bit, then at once.
// - Transfer takes one cycle; holding empties and buffer-empty flag sets.
// - Buffer-empty flag clears only by writing the holding register.
// - Read-only shift-empty bit, no interrupt, polled by software.
// - Wake event is a falling edge on the receive/data line.
`timescale 1ns/1ns
module sbs_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxdt_i,
	output logic rxdt_o,
	output logic rxdt_oe_n,
	output logic txck_o
);
	import sbs_pkg::*;

	sbs_ctrl_t ctrl_r;
	sbs_ctrl_t ctrl_nxt;
	sbs_tx_t tx_st_r;
	sbs_tx_t tx_st_nxt;
	sbs_rx_t rx_st_r;
	logic [15:0] baud_r;
	logic [15:0] bcnt_r;
	logic [15:0] rcnt_r;
	logic [7:0] hold_r;
	logic [7:0] rsh_r;
	logic [7:0] rdata_r;
	logic [13:0] fr_r;
	logic [13:0] fr_load;
	logic [3:0] cnt_r;
	logic [3:0] n_load;
	logic [3:0] rbit_r;
	logic hold_full_r;
	logic transmit_buffer_empty_flag_r;
	logic rcf_r;
	logic brk_act_r;
	logic ph_r;
	logic wk_seen_r;
	logic rx_m_r;
	logic rx_s_r;
	logic rx_d_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic txck_r;
	logic dt_r;
	logic dt_oe_n_r;
	logic txck_nxt;

	// Line synchroniser; only the second and third stages feed logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_m_r <= 1'b1;
			rx_s_r <= 1'b1;
			rx_d_r <= 1'b1;
		end else begin
			rx_m_r <= rxdt_i;
			rx_s_r <= rx_m_r;
			rx_d_r <= rx_s_r;
		end
	end

	// Line edges
	wire rx_fall = rx_d_r & ~rx_s_r;
	wire rx_rise = ~rx_d_r & rx_s_r;

	// APB decode
	wire apb_setup = psel & ~penable;
	wire apb_acc = psel & penable;
	wire hit_ctrl = paddr == SBS_A_CTRL;
	wire hit_stat = paddr == SBS_A_STAT;
	wire hit_txd = paddr == SBS_A_TXD;
	wire hit_rxd = paddr == SBS_A_RXD;
	wire hit_baud = paddr == SBS_A_BAUD;
	wire mapped = hit_ctrl | hit_stat | hit_txd | hit_rxd | hit_baud;
	wire wr_ctrl = apb_acc & pwrite & hit_ctrl;
	wire wr_baud = apb_acc & pwrite & hit_baud;
	wire wr_txd = apb_acc & pwrite & hit_txd;
	wire rd_rxd = apb_acc & ~pwrite & hit_rxd;

	// Status and transmit conditions
	wire tx_busy = tx_st_r == SBS_TX_SHIFT;
	wire shift_register_empty_status = tx_st_r == SBS_TX_IDLE;
	wire rx_busy = rx_st_r != SBS_RX_IDLE;
	wire rx_en = ctrl_r.serial_port_enable & ~ctrl_r.sync_mode;
	wire tick = bcnt_r == baud_r;
	wire bit_end = tx_busy & tick & (~ctrl_r.sync_mode | ph_r);
	wire tx_done = bit_end & (cnt_r == 4'h1);
	wire brk_done = tx_done & brk_act_r;
	wire can_load = hold_full_r & ctrl_r.transmit_enable & ctrl_r.serial_port_enable
		& ~(ctrl_r.sync_mode & rx_busy);
	wire brk_now = ctrl_r.send_break_request & ~ctrl_r.sync_mode;

	// Wake detection and receive completion
	wire wake_hit = rx_en & ctrl_r.wake_on_receive_enable & rx_fall & ~wk_seen_r;
	wire wake_clr = ctrl_r.wake_on_receive_enable & wk_seen_r & rx_rise;
	wire rx_ok = rx_st_r == SBS_RX_STOP && rcnt_r == baud_r && rx_s_r;
	wire rx_set = wake_hit | rx_ok;
	wire rx_go = rx_en & ~ctrl_r.wake_on_receive_enable & ~wk_seen_r & rx_fall;

	// Read mux
	wire [31:0] stat_w = {28'h0000000, ~rx_busy, rcf_r, shift_register_empty_status, transmit_buffer_empty_flag_r};
	wire [31:0] rd_val = hit_ctrl ? {23'h000000, ctrl_r} :
		hit_stat ? stat_w :
		hit_rxd ? {24'h000000, rdata_r} :
		hit_baud ? {16'h0000, baud_r} :
		hit_txd ? {24'h000000, hold_r} : 32'h00000000;

	// Frame to load: break pattern ignores the byte, sync has no start/stop
	assign fr_load = ctrl_r.sync_mode ? {5'h1F, ctrl_r.transmit_ninth_bit, hold_r} :
		brk_now ? SBS_BRK_FRAME :
		ctrl_r.nine_bit_transmit_select ? {4'hF, ctrl_r.transmit_ninth_bit, hold_r, 1'b0} :
		{5'h1F, hold_r, 1'b0};
	assign n_load = ctrl_r.sync_mode ? (ctrl_r.nine_bit_transmit_select ? SBS_N_S9 : SBS_N_S8) :
		brk_now ? SBS_N_BRK :
		ctrl_r.nine_bit_transmit_select ? SBS_N_A9 : SBS_N_A8;

	// Control next value; hardware clears applied after a software write
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
			ctrl_nxt = sbs_ctrl_t'(pwdata[8:0]);
		if (brk_done)
			ctrl_nxt.send_break_request = 1'b0;
		if (wake_clr)
			ctrl_nxt.wake_on_receive_enable = 1'b0;
	end

	// Transmit sequencer next state
	always_comb begin
		case (tx_st_r)
			SBS_TX_IDLE: tx_st_nxt = can_load ? SBS_TX_LOAD : SBS_TX_IDLE;
			SBS_TX_LOAD: tx_st_nxt = SBS_TX_SHIFT;
			SBS_TX_SHIFT: tx_st_nxt = !tx_done ? SBS_TX_SHIFT :
				(can_load ? SBS_TX_LOAD : SBS_TX_IDLE);
			default: tx_st_nxt = SBS_TX_IDLE;
		endcase
	end

	// Pin roles: in sync mode the transmit pin carries the shift clock
	always_comb begin
		if (!ctrl_r.serial_port_enable)
			txck_nxt = 1'b1;
		else if (ctrl_r.sync_mode) begin
			if (ctrl_r.clock_source_select & tx_busy)
				txck_nxt = ph_r ^ ctrl_r.clock_idle_polarity;
			else
				txck_nxt = ctrl_r.clock_idle_polarity;
		end else
			txck_nxt = tx_busy ? fr_r[0] : 1'b1;
	end

	// Control and baud registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= sbs_ctrl_t'(SBS_CTRL_RST);
			baud_r <= SBS_BAUD_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			if (wr_baud)
				baud_r <= pwdata[15:0];
		end
	end

	// APB answer registered in setup, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (apb_setup) begin
			prdata_r <= pwrite ? 32'h00000000 : rd_val;
			pslverr_r <= ~mapped;
		end
	end

	// Holding register and buffer-empty flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= 8'h00;
			hold_full_r <= 1'b0;
			transmit_buffer_empty_flag_r <= 1'b1;
		end else if (wr_txd) begin
			hold_r <= pwdata[7:0];
			hold_full_r <= 1'b1;
			transmit_buffer_empty_flag_r <= 1'b0;
		end else if (tx_st_r == SBS_TX_LOAD) begin
			hold_full_r <= 1'b0;
			transmit_buffer_empty_flag_r <= 1'b1;
		end
	end

	// Transmit shifter and bit timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r <= SBS_TX_IDLE;
			fr_r <= 14'h3FFF;
			cnt_r <= 4'h0;
			brk_act_r <= 1'b0;
			ph_r <= 1'b0;
			bcnt_r <= 16'h0000;
		end else begin
			tx_st_r <= tx_st_nxt;
			if (tx_st_r == SBS_TX_LOAD) begin
				fr_r <= fr_load;
				cnt_r <= n_load;
				brk_act_r <= brk_now;
				ph_r <= 1'b0;
				bcnt_r <= 16'h0000;
			end else if (tx_busy) begin
				bcnt_r <= tick ? 16'h0000 : bcnt_r + 16'h0001;
				if (tick & ctrl_r.sync_mode)
					ph_r <= ~ph_r;
				if (bit_end) begin
					fr_r <= {1'b1, fr_r[13:1]};
					cnt_r <= cnt_r - 4'h1;
				end
			end
		end
	end

	// Pin output flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txck_r <= 1'b1;
			dt_r <= 1'b1;
			dt_oe_n_r <= 1'b1;
		end else begin
			txck_r <= txck_nxt;
			dt_r <= fr_r[0];
			dt_oe_n_r <= ~(ctrl_r.serial_port_enable & ctrl_r.sync_mode & tx_busy);
		end
	end

	// Wake tracking and receive-complete flag; a new event beats a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wk_seen_r <= 1'b0;
			rcf_r <= 1'b0;
		end else begin
			rcf_r <= rx_set | (rcf_r & ~rd_rxd);
			if (wake_hit)
				wk_seen_r <= 1'b1;
			else if (wake_clr | ~ctrl_r.wake_on_receive_enable)
				wk_seen_r <= 1'b0;
		end
	end

	// Asynchronous receiver, idle while wake mode holds it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r <= SBS_RX_IDLE;
			rcnt_r <= 16'h0000;
			rbit_r <= 4'h0;
			rsh_r <= 8'h00;
			rdata_r <= 8'h00;
		end else begin
			rcnt_r <= rcnt_r + 16'h0001;
			if (wake_hit)
				rdata_r <= 8'h00;
			case (rx_st_r)
				SBS_RX_IDLE: begin
					rcnt_r <= 16'h0000;
					if (rx_go)
						rx_st_r <= SBS_RX_START;
				end
				SBS_RX_START: if (rcnt_r == {1'b0, baud_r[15:1]}) begin
					rcnt_r <= 16'h0000;
					rbit_r <= 4'h0;
					rx_st_r <= rx_s_r ? SBS_RX_IDLE : SBS_RX_DATA;
				end
				SBS_RX_DATA: if (rcnt_r == baud_r) begin
					rcnt_r <= 16'h0000;
					rsh_r <= {rx_s_r, rsh_r[7:1]};
					rbit_r <= rbit_r + 4'h1;
					if (rbit_r == SBS_N_RXD - 4'h1)
						rx_st_r <= SBS_RX_STOP;
				end
				SBS_RX_STOP: if (rcnt_r == baud_r) begin
					if (rx_ok)
						rdata_r <= rsh_r;
					rx_st_r <= SBS_RX_IDLE;
				end
				default: rx_st_r <= SBS_RX_IDLE;
			endcase
			if (!rx_en || ctrl_r.wake_on_receive_enable)
				rx_st_r <= SBS_RX_IDLE;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = pslverr_r;
	assign rxdt_o = dt_r;
	assign rxdt_oe_n = dt_oe_n_r;
	assign txck_o = txck_r;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_wake_sets_flag: assert property (wake_hit |=> rcf_r)
		else $error("wake event did not set receive flag");
	a_wake_auto_clear: assert property (wake_clr |=> !ctrl_r.wake_on_receive_enable && !wk_seen_r)
		else $error("wake enable not cleared on rising edge");
	a_rxread_clears: assert property (rd_rxd && !rx_set |=> !rcf_r)
		else $error("receive data read did not clear flag");
	a_break_low: assert property (tx_busy && brk_act_r && cnt_r > 4'h1 |=> txck_r == 1'b0)
		else $error("break bit not low");
	a_break_len: assert property (tx_st_r == SBS_TX_LOAD && brk_now |=> cnt_r == SBS_N_BRK && fr_r == SBS_BRK_FRAME)
		else $error("break frame wrong");
	a_break_done: assert property (brk_done |=> !ctrl_r.send_break_request ##1 tx_st_r != SBS_TX_SHIFT || !brk_act_r)
		else $error("send break not cleared after stop bit");
	a_load_flag: assert property (tx_st_r == SBS_TX_LOAD && !wr_txd |=> transmit_buffer_empty_flag_r && !hold_full_r && tx_busy)
		else $error("transfer did not empty holding register");
	a_txd_write: assert property (wr_txd |=> !transmit_buffer_empty_flag_r && hold_full_r && hold_r == $past(pwdata[7:0]))
		else $error("holding write did not clear empty flag");
	a_reload_wait: assert property ($rose(tx_st_r == SBS_TX_LOAD) |-> $past(shift_register_empty_status) || $past(tx_done))
		else $error("shift register reloaded mid word");
	a_idle_clock: assert property (ctrl_r.serial_port_enable && ctrl_r.sync_mode && shift_register_empty_status && $stable(ctrl_r)
		|=> txck_r == $past(ctrl_r.clock_idle_polarity))
		else $error("sync clock not at idle level");
	a_half_duplex: assert property (ctrl_r.sync_mode && rx_busy |-> tx_st_nxt != SBS_TX_LOAD || tx_busy)
		else $error("transmit started while receiving");
	a_lsb_first: assert property (tx_st_r == SBS_TX_LOAD && ctrl_r.sync_mode |=> fr_r[0] == $past(hold_r[0]))
		else $error("sync word not LSB first");

	// Wake idling, break hand-over, pin roles and buffer-empty flag
	a_rx_idle_wake: assert property (ctrl_r.wake_on_receive_enable |=> rx_st_r == SBS_RX_IDLE)
		else $error("receiver not idle in wake mode");
	a_break_handover: assert property (brk_done && can_load |=> tx_st_r == SBS_TX_LOAD && !ctrl_r.send_break_request)
		else $error("byte after break not loaded");
	a_data_driven: assert property (ctrl_r.serial_port_enable && ctrl_r.sync_mode && tx_busy |=> !rxdt_oe_n)
		else $error("data line not driven while shifting");
	a_clock_active: assert property (ctrl_r.serial_port_enable && ctrl_r.sync_mode && ctrl_r.clock_source_select
		&& tx_busy && ph_r |=> txck_r != $past(ctrl_r.clock_idle_polarity))
		else $error("shift clock not at active level");
	a_port_off_pins: assert property (!ctrl_r.serial_port_enable |=> txck_r && rxdt_oe_n)
		else $error("pins not released with port off");
	a_transmit_buffer_empty_flag_hold: assert property (transmit_buffer_empty_flag_r && !wr_txd |=> transmit_buffer_empty_flag_r)
		else $error("buffer-empty flag cleared without a write");
endmodule : sbs_top

// *** tb.sv ***
// Self-checking bench for the break/sync serial port
`timescale 1ns/1ns
module tb;
	import sbs_pkg::*;
	localparam logic [31:0] C_TRANSMIT_ENABLE = 32'h1, C_BRK = 32'h2, C_SYNC = 32'h4, C_CSS = 32'h8, C_PEN = 32'h10;
	localparam logic [31:0] C_POL = 32'h20, C_NINE = 32'h40, C_NINTH = 32'h80, C_WAKE = 32'h100;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxdt_o, rxdt_oe_n, txck_o;
	logic go, line, peer_busy;
	logic [7:0] paddr, peer_val;
	logic [31:0] pwdata, prdata;
	int bad_count;
	int total_checks;

	sbs_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxdt_i(line), .rxdt_o(rxdt_o), .rxdt_oe_n(rxdt_oe_n), .txck_o(txck_o));
	sbs_lin_peer i_peer (.line(line), .busy(peer_busy), .go(go), .val(peer_val));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// Compare a register word
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_word

	// Compare a single pin or bit
	task automatic chk_bit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_bit

	// One APB transfer, entered just after a rising edge, one idle cycle after it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk_word(r, exp, what);
	endtask : rd_chk

	task automatic rd_bit(input logic [7:0] a, input int pos, input logic exp, input string what);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk_bit(r[pos], exp, what);
	endtask : rd_bit

	// Bounded wait for the tx pin or the peer line to reach a level
	task automatic wait_lvl(input bit on_line, input logic v);
		int k;
		k = 0;
		while ((on_line ? line : txck_o) !== v && k < 400) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 400) begin
			bad_count++;
			$display("CHECK FAILED at %0t: timeout waiting for line level", $time);
		end
	endtask : wait_lvl

	// Bounded wait for the peer to finish its sequence
	task automatic wait_peer();
		int k;
		k = 0;
		while (peer_busy !== 1'b0 && k < 400) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 400) begin
			bad_count++;
			$display("CHECK FAILED at %0t: timeout waiting for peer", $time);
		end
	endtask : wait_peer

	// Sample one async frame mid-bit, eight clocks per bit
	task automatic tx_frame(input int n, input logic [15:0] bits, input string what);
		wait_lvl(1'b0, 1'b0);
		repeat (4) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			chk_bit(txck_o, bits[i], what);
			if (i < n - 1) repeat (8) @(posedge pclk);
		end
	endtask : tx_frame

	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rd_chk(SBS_A_CTRL, 32'h0, "ctrl reset");
		rd_chk(SBS_A_BAUD, 32'hF, "baud reset");
		rd_chk(SBS_A_STAT, 32'hB, "stat reset");
		wr(SBS_A_STAT, 32'h0);
		rd_chk(SBS_A_STAT, 32'hB, "stat ignores writes");
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk_bit(e, 1'b1, "unmapped error");
		$display("test reset_regs done");
	endtask : t_reset

	task automatic t_lin();
		wr(SBS_A_BAUD, 32'h7);
		fork
			begin
				tx_frame(14, 16'h2000, "break bits");
				tx_frame(10, 16'h02AA, "sync byte");
			end
			begin
				wr(SBS_A_CTRL, C_TRANSMIT_ENABLE | C_BRK | C_PEN);
				wr(SBS_A_TXD, 32'hA5);
				repeat (4) @(posedge pclk);
				rd_chk(SBS_A_STAT, 32'h9, "holding emptied at load");
				wr(SBS_A_TXD, 32'h55);
				rd_chk(SBS_A_STAT, 32'h8, "busy during break");
				rd_chk(SBS_A_CTRL, C_TRANSMIT_ENABLE | C_BRK | C_PEN, "break bit held");
			end
		join
		repeat (20) @(posedge pclk);
		rd_chk(SBS_A_CTRL, C_TRANSMIT_ENABLE | C_PEN, "break bit cleared");
		rd_chk(SBS_A_STAT, 32'hB, "idle after header");
		wr(SBS_A_CTRL, 32'h0);
		$display("test lin_header done");
	endtask : t_lin

	task automatic t_sync(input logic pol, input logic nine, input logic ninth, input logic [7:0] w0,
		input logic [7:0] w1);
		logic [31:0] cw;
		logic [7:0] w;
		int nb;
		int b;
		cw = C_TRANSMIT_ENABLE | C_SYNC | C_CSS | C_PEN | (pol ? C_POL : 32'h0) | (nine ? C_NINE : 32'h0);
		cw = cw | (ninth ? C_NINTH : 32'h0);
		nb = nine ? 9 : 8;
		wr(SBS_A_CTRL, cw);
		repeat (4) @(posedge pclk);
		chk_bit(txck_o, pol, "clock idle level");
		chk_bit(rxdt_oe_n, 1'b1, "data released idle");
		wr(SBS_A_TXD, {24'h0, w0});
		wr(SBS_A_TXD, {24'h0, w1});
		for (int j = 0; j < 2 * nb; j++) begin
			b = j % nb;
			w = (j < nb) ? w0 : w1;
			wait_lvl(1'b0, ~pol);
			repeat (4) @(posedge pclk);
			chk_bit(rxdt_o, (b < 8) ? w[b] : ninth, "sync data bit");
			chk_bit(rxdt_oe_n, 1'b0, "data driven");
			wait_lvl(1'b0, pol);
		end
		repeat (40) @(posedge pclk);
		chk_bit(txck_o, pol, "clock back idle");
		chk_bit(rxdt_oe_n, 1'b1, "data released after");
		rd_chk(SBS_A_STAT, 32'hB, "sync idle status");
		wr(SBS_A_CTRL, 32'h0);
		$display("test sync_master done");
	endtask : t_sync

	task automatic t_wake();
		int k;
		rd_bit(SBS_A_STAT, SBS_S_RXIDLE, 1'b1, "receiver idle before sleep");
		wr(SBS_A_CTRL, C_WAKE | C_PEN);
		peer_val <= 8'h96;
		go <= 1'b1;
		repeat (30) @(posedge pclk);
		rd_bit(SBS_A_STAT, SBS_S_RCF, 1'b1, "wake flag set");
		rd_chk(SBS_A_CTRL, C_WAKE | C_PEN, "wake held while low");
		wait_lvl(1'b1, 1'b1);
		repeat (8) @(posedge pclk);
		rd_chk(SBS_A_CTRL, C_PEN, "wake cleared on rise");
		rd_chk(SBS_A_RXD, 32'h0, "dummy data");
		rd_bit(SBS_A_STAT, SBS_S_RCF, 1'b0, "flag cleared by read");
		wait_peer();
		rd_bit(SBS_A_STAT, SBS_S_RCF, 1'b1, "byte after break");
		rd_chk(SBS_A_RXD, 32'h96, "byte value");
		go <= 1'b0;
		$display("test wake_break done");
	endtask : t_wake

	// Break received as an ordinary zero byte at two-thirds of the bit rate
	task automatic t_brk();
		wr(SBS_A_BAUD, 32'hB);
		wr(SBS_A_CTRL, C_PEN);
		peer_val <= 8'hFF;
		go <= 1'b1;
		wait_lvl(1'b1, 1'b0);
		wait_lvl(1'b1, 1'b1);
		repeat (16) @(posedge pclk);
		rd_bit(SBS_A_STAT, SBS_S_RCF, 1'b1, "break taken as character");
		rd_chk(SBS_A_RXD, 32'h0, "break reads as zero byte");
		wait_peer();
		go <= 1'b0;
		$display("test break_as_char done");
	endtask : t_brk

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		conclude();
	end

	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		go = 1'b0;
		peer_val = 8'h00;
		bad_count = 0;
		total_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_lin();
		t_sync(1'b1, 1'b1, 1'b1, 8'hC3, 8'h3C);
		t_sync(1'b0, 1'b0, 1'b0, 8'hA5, 8'h0F);
		t_wake();
		t_brk();
		conclude();
	end
endmodule : tb
